//--- include/pdmx_pkg.sv
// Constants for the digital microphone input front end and path enables
package pdmx_pkg;

	// Register offsets on the register port
	localparam logic [15:0] ADDR_INPUT_PATH_ENABLES = 16'h0300;
	localparam logic [15:0] ADDR_INPUT_PATH_ENABLE_STATUS = 16'h0301;
	localparam logic [15:0] ADDR_PATH1_CONTROL = 16'h0310;
	localparam logic [15:0] ADDR_PATH2_CONTROL = 16'h0318;

	// Enable and status bit positions
	localparam int BIT_PATH2 = 3;
	localparam int BIT_PATH1_LEFT = 1;
	localparam int BIT_PATH1_RIGHT = 0;

	// Path control fields
	localparam int BIT_PAIR_INPUT_SELECT = 10;
	localparam int OSR_MSB = 14;
	localparam int OSR_LSB = 13;
	localparam logic [1:0] OSR_RESET = 2'h1;
	localparam logic [15:0] CONTROL_RESET = 16'h2000;
	localparam logic [15:0] ENABLES_RESET = 16'h0000;

	localparam logic [1:0] OSR_1536K = 2'h0;
	localparam logic [1:0] OSR_3072K = 2'h1;
	localparam logic [1:0] OSR_RESERVED = 2'h2;
	localparam logic [1:0] OSR_768K = 2'h3;

	// Clock rates in Hz, nominal and fractional base
	localparam longint CORE_CLK_HZ = 100000000;
	localparam longint MIC_HZ_1536K = 1536000;
	localparam longint MIC_HZ_3072K = 3072000;
	localparam longint MIC_HZ_768K = 768000;
	localparam longint BASE_NOMINAL_HZ = 6144000;
	localparam longint BASE_FRAC_HZ = 5644800;

	// Half periods of the mic clock in core cycles, rounded down
	localparam logic [7:0] HALF_1536K = 8'(CORE_CLK_HZ / (2 * MIC_HZ_1536K));
	localparam logic [7:0] HALF_3072K = 8'(CORE_CLK_HZ / (2 * MIC_HZ_3072K));
	localparam logic [7:0] HALF_768K = 8'(CORE_CLK_HZ / (2 * MIC_HZ_768K));
	localparam logic [7:0] HALF_1536K_FRAC =
		8'((CORE_CLK_HZ * BASE_NOMINAL_HZ) / (2 * MIC_HZ_1536K * BASE_FRAC_HZ));
	localparam logic [7:0] HALF_3072K_FRAC =
		8'((CORE_CLK_HZ * BASE_NOMINAL_HZ) / (2 * MIC_HZ_3072K * BASE_FRAC_HZ));
	localparam logic [7:0] HALF_768K_FRAC =
		8'((CORE_CLK_HZ * BASE_NOMINAL_HZ) / (2 * MIC_HZ_768K * BASE_FRAC_HZ));

	// Fewest core cycles per mic clock phase that capture can run on
	localparam logic [7:0] MIN_HALF_CYCLES = 8'h04;

endpackage

//--- logic/pdmx_mic_if.sv
// Mic clock generator and phase-end data capture for one interface
`timescale 1ns/1ns
module pdmx_mic_if
	import pdmx_pkg::*;
#(
	parameter bit STEREO = 1'b1
)(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic [7:0] i_half_cycles,
	input wire logic i_data_sync,
	output logic o_mic_clk,
	output logic o_left_bit,
	output logic o_left_valid,
	output logic o_right_bit,
	output logic o_right_valid
);

	logic [7:0] cnt_r, cnt_nxt;
	logic clk_r, clk_nxt;
	logic lbit_r, lbit_nxt, lval_r, lval_nxt;
	logic rbit_r, rbit_nxt, rval_r, rval_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		clk_nxt = clk_r;
		lbit_nxt = lbit_r;
		rbit_nxt = rbit_r;
		lval_nxt = 1'b0;
		rval_nxt = 1'b0;
		if (!i_run)
		begin
			// Parked low while nothing on this interface is enabled
			cnt_nxt = 8'h00;
			clk_nxt = 1'b0;
		end
		else if (cnt_r >= i_half_cycles - 8'h01)
		begin
			cnt_nxt = 8'h00;
			clk_nxt = ~clk_r;
			// Sample at the end of each phase: high to left, low to right only when STEREO
			if (clk_r)
			begin
				lbit_nxt = i_data_sync;
				lval_nxt = 1'b1;
			end
			else if (STEREO)
			begin
				rbit_nxt = i_data_sync;
				rval_nxt = 1'b1;
			end
		end
		else
		begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			cnt_r <= 8'h00;
			clk_r <= 1'b0;
			lbit_r <= 1'b0;
			lval_r <= 1'b0;
			rbit_r <= 1'b0;
			rval_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			clk_r <= clk_nxt;
			lbit_r <= lbit_nxt;
			lval_r <= lval_nxt;
			rbit_r <= rbit_nxt;
			rval_r <= rval_nxt;
		end
	end

	assign o_mic_clk = clk_r;
	assign o_left_bit = lbit_r;
	assign o_left_valid = lval_r;
	assign o_right_bit = rbit_r;
	assign o_right_valid = rval_r;

endmodule // pdmx_mic_if

//--- logic/pdmx_input_path.sv
// Digital microphone input front end with input path enable control
//
// Operation
// - One mode bit serves both channels of pair
// - Stereo line two channels, mono one, own clocks
// - Enabled digital path drives its interface clock
// - Oversample code picks mic clock rate
// - Fractional core clock scales mic clock rates
// - Sample each phase end: high left, low right
// - Mono line: left only, high phase bit
// - Enable bits 3, 1, 0; reset to zero
// - Underclocked enable fails; running paths unaffected
// - Failed enable raises underclock error
// - Status register shows paths actually enabled
// - Mode bit 10: analogue 0, digital 1
// - Oversample bits 14:13 reset 01; 10 reserved
`timescale 1ns/1ns
module pdmx_input_path
	import pdmx_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_core_system_clock_en,
	input wire logic i_core_clock_fractional_flag,
	input wire logic i_mic_stereo_data_in,
	input wire logic i_mic_mono_data_in,
	output logic [15:0] o_reg_rdata,
	output logic o_mic_stereo_clk_out,
	output logic o_mic_mono_clk_out,
	output logic o_path1_left_bit,
	output logic o_path1_left_valid,
	output logic o_path1_right_bit,
	output logic o_path1_right_valid,
	output logic o_path2_bit,
	output logic o_path2_valid,
	output logic o_underclock_err
);

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: first stage feeds only the second
	logic [3:0] sync1_r, sync2_r;

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end
		else
		begin
			sync1_r <= {i_core_system_clock_en, i_core_clock_fractional_flag,
				i_mic_stereo_data_in, i_mic_mono_data_in};
			sync2_r <= sync1_r;
		end
	end

	logic core_system_clock_en_s, frac_s, stereo_data_s, mono_data_s;
	assign core_system_clock_en_s = sync2_r[3];
	assign frac_s = sync2_r[2];
	assign stereo_data_s = sync2_r[1];
	assign mono_data_s = sync2_r[0];

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [15:0] enables_r, enables_nxt;
	logic [15:0] status_r, status_nxt;
	logic [15:0] ctrl1_r, ctrl1_nxt;
	logic [15:0] ctrl2_r, ctrl2_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;

	logic [7:0] half1, half2;
	logic short1, short2;

	// Half period in core cycles per oversample code and clock base
	function automatic logic [7:0] half_for(input logic [1:0] osr, input logic frac);
		logic [7:0] h;
		h = 8'h00;
		case (osr)
			OSR_1536K: h = frac ? HALF_1536K_FRAC : HALF_1536K;
			OSR_3072K: h = frac ? HALF_3072K_FRAC : HALF_3072K;
			OSR_768K: h = frac ? HALF_768K_FRAC : HALF_768K;
			default: h = 8'h00; // Reserved code counts as unsupportable
		endcase
		return h;
	endfunction

	always_comb
	begin
		half1 = half_for(ctrl1_r[OSR_MSB:OSR_LSB], frac_s);
		half2 = half_for(ctrl2_r[OSR_MSB:OSR_LSB], frac_s);
		// Too few core cycles: no system clock, or phase too short to capture
		short1 = !core_system_clock_en_s || (half1 < MIN_HALF_CYCLES);
		short2 = !core_system_clock_en_s || (half2 < MIN_HALF_CYCLES);
	end

	always_comb
	begin
		logic [15:0] wr_en;
		logic [15:0] rise;
		logic fail;
		wr_en = 16'h0000;
		rise = 16'h0000;
		fail = 1'b0;
		enables_nxt = enables_r;
		status_nxt = status_r;
		ctrl1_nxt = ctrl1_r;
		ctrl2_nxt = ctrl2_r;
		err_nxt = 1'b0;
		if (i_reg_wr)
		begin
			case (i_reg_addr)
				ADDR_INPUT_PATH_ENABLES:
				begin
					wr_en = 16'h0000;
					wr_en[BIT_PATH2] = i_reg_wdata[BIT_PATH2];
					wr_en[BIT_PATH1_LEFT] = i_reg_wdata[BIT_PATH1_LEFT];
					wr_en[BIT_PATH1_RIGHT] = i_reg_wdata[BIT_PATH1_RIGHT];
					enables_nxt = wr_en;
					rise = wr_en & ~status_r;
					// Disabling is immediate; running paths keep running
					status_nxt = status_r & wr_en;
					if (rise[BIT_PATH2])
					begin
						if (short2)
							fail = 1'b1;
						else
							status_nxt[BIT_PATH2] = 1'b1;
					end
					if (rise[BIT_PATH1_LEFT])
					begin
						if (short1)
							fail = 1'b1;
						else
							status_nxt[BIT_PATH1_LEFT] = 1'b1;
					end
					if (rise[BIT_PATH1_RIGHT])
					begin
						if (short1)
							fail = 1'b1;
						else
							status_nxt[BIT_PATH1_RIGHT] = 1'b1;
					end
					err_nxt = fail;
				end
				ADDR_PATH1_CONTROL:
				begin
					// Only mode and oversample fields live here
					ctrl1_nxt = 16'h0000;
					ctrl1_nxt[BIT_PAIR_INPUT_SELECT] = i_reg_wdata[BIT_PAIR_INPUT_SELECT];
					ctrl1_nxt[OSR_MSB:OSR_LSB] = i_reg_wdata[OSR_MSB:OSR_LSB];
				end
				ADDR_PATH2_CONTROL:
				begin
					ctrl2_nxt = 16'h0000;
					ctrl2_nxt[BIT_PAIR_INPUT_SELECT] = i_reg_wdata[BIT_PAIR_INPUT_SELECT];
					ctrl2_nxt[OSR_MSB:OSR_LSB] = i_reg_wdata[OSR_MSB:OSR_LSB];
				end
				default:
				begin
					enables_nxt = enables_r;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			enables_r <= ENABLES_RESET;
			status_r <= ENABLES_RESET;
			ctrl1_r <= CONTROL_RESET;
			ctrl2_r <= CONTROL_RESET;
			err_r <= 1'b0;
		end
		else
		begin
			enables_r <= enables_nxt;
			status_r <= status_nxt;
			ctrl1_r <= ctrl1_nxt;
			ctrl2_r <= ctrl2_nxt;
			err_r <= err_nxt;
		end
	end

	assign o_underclock_err = err_r;

	////////////////////////////////////////////////////////////////////////////
	// Read port: a read strobe loads the word, which then stands until the next one
	// A read in the same cycle as a write returns the old word
	always_comb
	begin
		rdata_nxt = rdata_r;
		if (i_reg_rd)
		begin
			case (i_reg_addr)
				ADDR_INPUT_PATH_ENABLES: rdata_nxt = enables_r;
				ADDR_INPUT_PATH_ENABLE_STATUS: rdata_nxt = status_r;
				ADDR_PATH1_CONTROL: rdata_nxt = ctrl1_r;
				ADDR_PATH2_CONTROL: rdata_nxt = ctrl2_r;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rdata_r <= 16'h0000;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_reg_rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////////
	// Microphone interfaces
	logic run1, run2;
	// One mode bit covers both channels of the stereo pair
	assign run1 = ctrl1_r[BIT_PAIR_INPUT_SELECT]
		&& (status_r[BIT_PATH1_LEFT] || status_r[BIT_PATH1_RIGHT]);
	assign run2 = ctrl2_r[BIT_PAIR_INPUT_SELECT] && status_r[BIT_PATH2];

	logic s_lbit, s_lval, s_rbit, s_rval;

	// Stereo line: both phases, own clock
	pdmx_mic_if #(
		.STEREO(1'b1)
	) u_stereo (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_run(run1),
		.i_half_cycles(half1),
		.i_data_sync(stereo_data_s),
		.o_mic_clk(o_mic_stereo_clk_out),
		.o_left_bit(s_lbit),
		.o_left_valid(s_lval),
		.o_right_bit(s_rbit),
		.o_right_valid(s_rval)
	);

	// Mono line: high phase only, left channel
	pdmx_mic_if #(
		.STEREO(1'b0)
	) u_mono (
		.i_core_clk(i_core_clk),
		.i_reset(i_reset),
		.i_run(run2),
		.i_half_cycles(half2),
		.i_data_sync(mono_data_s),
		.o_mic_clk(o_mic_mono_clk_out),
		.o_left_bit(o_path2_bit),
		.o_left_valid(o_path2_valid),
		.o_right_bit(),
		.o_right_valid()
	);

	////////////////////////////////////////////////////////////////////////////
	// Pair output stage
	// A pair channel that is not enabled delivers no samples. The gate is
	// registered so the pins come from flops; bit and valid lag one cycle together.
	logic [3:0] pair_out_r, pair_out_nxt;

	always_comb
	begin
		pair_out_nxt = {s_lbit, s_lval & status_r[BIT_PATH1_LEFT],
			s_rbit, s_rval & status_r[BIT_PATH1_RIGHT]};
	end

	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pair_out_r <= 4'h0;
		end
		else
		begin
			pair_out_r <= pair_out_nxt;
		end
	end

	assign o_path1_left_bit = pair_out_r[3];
	assign o_path1_left_valid = pair_out_r[2];
	assign o_path1_right_bit = pair_out_r[1];
	assign o_path1_right_valid = pair_out_r[0];

endmodule // pdmx_input_path

//--- verification/pdmx_input_path_assertions.sv
// Checker for the mic front end: capture phases, pulses and register port
`timescale 1ns/1ns
module pdmx_input_path_chk
	import pdmx_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_mic_stereo_clk_out,
	input wire logic o_path1_left_valid,
	input wire logic o_path1_right_valid,
	input wire logic o_path2_valid,
	input wire logic o_mic_mono_clk_out,
	input wire logic o_underclock_err
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	logic en_try_r;
	logic unmapped;
	assign unmapped = !(i_reg_addr inside {ADDR_INPUT_PATH_ENABLES,
		ADDR_INPUT_PATH_ENABLE_STATUS, ADDR_PATH1_CONTROL, ADDR_PATH2_CONTROL});
	// An enable attempt is a write to the enables that sets some path bit
	always_ff @(posedge i_core_clk or posedge i_reset)
		if (i_reset)
			en_try_r <= 1'b0;
		else
			en_try_r <= i_reg_wr && i_reg_addr == ADDR_INPUT_PATH_ENABLES
				&& (i_reg_wdata & 16'h000B) != 16'h0000;
	a_left_phase: assert property (o_path1_left_valid |-> !o_mic_stereo_clk_out)
		else $error("left sample not at high phase end");
	a_right_phase: assert property (o_path1_right_valid |-> o_mic_stereo_clk_out)
		else $error("right sample not at low phase end");
	a_mono_phase: assert property (o_path2_valid |-> !o_mic_mono_clk_out)
		else $error("mono sample not at high phase end");
	a_valid_pulse: assert property ((o_path1_left_valid || o_path1_right_valid)
		|=> !(o_path1_left_valid || o_path1_right_valid))
		else $error("stereo valid longer than one cycle");
	a_low_phase_min: assert property ($fell(o_mic_stereo_clk_out)
		|=> !o_mic_stereo_clk_out [*8])
		else $error("stereo clock low phase too short");
	a_err_cause: assert property (o_underclock_err |-> en_try_r)
		else $error("underclock error without enable attempt");
	a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (i_reg_rd && unmapped |=> o_reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	c_left: cover property (o_path1_left_valid);
	c_right: cover property (o_path1_right_valid);
	c_mono: cover property (o_path2_valid);
	c_err: cover property (o_underclock_err);
endmodule // pdmx_input_path_chk

bind pdmx_input_path pdmx_input_path_chk i_chk (.i_core_clk, .i_reset, .i_reg_wr,
	.i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_mic_stereo_clk_out,
	.o_path1_left_valid, .o_path1_right_valid, .o_path2_valid, .o_mic_mono_clk_out,
	.o_underclock_err);

//--- verification/pdmx_mic_model.sv
// Behavioural stereo mic pair and mono mic on the data lines
`timescale 1ns/1ns
module pdmx_mic_model
(
	input wire logic i_stereo_clk,
	input wire logic i_mono_clk,
	input wire logic i_left_val,
	input wire logic i_right_val,
	output logic o_stereo_data,
	output logic o_mono_data
);
	// Left talks while high, right while low, each silent in the other's phase
	assign o_stereo_data = i_stereo_clk ? i_left_val : i_right_val;
	// Released line falls to the pull-down level in the low phase
	assign o_mono_data = i_mono_clk ? 1'b1 : 1'b0;
endmodule // pdmx_mic_model

//--- verification/tb_pdmx_input_path.sv
// Self-checking bench for the mic front end and input path enables
`timescale 1ns/1ns
module tb_pdmx_input_path import pdmx_pkg::*;;
	logic i_core_clk, i_reset, i_reg_wr, i_reg_rd, sys_en, frac, lv, rv, msel, last_err;
	logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic s_dat, m_dat, s_clk, m_clk, l_bit, l_vld, r_bit, r_vld, m_bit, m_vld, err;
	int num_errors = 0;
	int checks = 0;
	int n;
	// Oversample code, fractional flag, expected half period
	logic [10:0] rows [6] = '{{OSR_1536K, 1'b0, HALF_1536K}, {OSR_3072K, 1'b0, HALF_3072K},
		{OSR_768K, 1'b0, HALF_768K}, {OSR_1536K, 1'b1, HALF_1536K_FRAC},
		{OSR_3072K, 1'b1, HALF_3072K_FRAC}, {OSR_768K, 1'b1, HALF_768K_FRAC}};
	wire mclk = msel ? m_clk : s_clk;

	pdmx_input_path i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
		.i_core_system_clock_en(sys_en), .i_core_clock_fractional_flag(frac),
		.i_mic_stereo_data_in(s_dat), .i_mic_mono_data_in(m_dat), .o_reg_rdata(o_reg_rdata),
		.o_mic_stereo_clk_out(s_clk), .o_mic_mono_clk_out(m_clk), .o_path1_left_bit(l_bit),
		.o_path1_left_valid(l_vld), .o_path1_right_bit(r_bit), .o_path1_right_valid(r_vld),
		.o_path2_bit(m_bit), .o_path2_valid(m_vld), .o_underclock_err(err));
	pdmx_mic_model i_mics (.i_stereo_clk(s_clk), .i_mono_clk(m_clk), .i_left_val(lv),
		.i_right_val(rv), .o_stereo_data(s_dat), .o_mono_data(m_dat));

	////////////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Strobe is dropped with an idle cycle after, so strobes never meet
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		step;
		i_reg_wr = 1'b0;
		last_err = err;
		step;
	endtask
	task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		step;
		i_reg_rd = 1'b0;
		chk(what, exp, o_reg_rdata);
		step;
	endtask
	task automatic meas;
		n = 0;
		while (mclk !== 1'b1 && n < 300)
		begin
			step;
			n++;
		end
		chk("clock rise", 16'h0001, 16'(mclk));
		n = 0;
		while (mclk === 1'b1 && n < 300)
		begin
			step;
			n++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge i_core_clk)
	begin
		if (l_vld === 1'b1)
			chk("left bit", 16'(lv), 16'(l_bit));
		if (r_vld === 1'b1)
			chk("right bit", 16'(rv), 16'(r_bit));
		if (m_vld === 1'b1)
			chk("mono bit", 16'h0001, 16'(m_bit));
	end
	initial
	begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// Roughly ten times the expected run length
	initial
	begin
		#150000;
		num_errors++;
		complete_run;
	end
	initial
	begin
		{i_reset, i_reg_wr, i_reg_rd, frac, lv, rv, msel, last_err} = 8'h80;
		{i_reg_addr, i_reg_wdata} = 32'h0000_0000;
		sys_en = 1'b1; // Core clock runs before any enable
		repeat (2) @(posedge i_core_clk);
		#1;
		i_reset = 1'b0;
		repeat (3) step;
		// 768 kHz rows assume an input rate of 8 to 16 kHz
		for (int k = 0; k < 6; k++)
		begin
			frac = rows[k][8];
			lv = k[0];
			rv = !lv;
			repeat (3) step;
			wr(ADDR_PATH1_CONTROL, 16'h0400 | (16'(rows[k][10:9]) << OSR_LSB));
			wr(ADDR_INPUT_PATH_ENABLES, 16'h0003);
			rdc("status", ADDR_INPUT_PATH_ENABLE_STATUS, 16'h0003);
			meas;
			chk("half period", 16'(rows[k][7:0]), 16'(n));
			meas;
			chk("half period 2", 16'(rows[k][7:0]), 16'(n));
			// Disable two cycles into the high phase so the forced low is seen
			repeat (int'(rows[k][7:0]) + 2) step;
			wr(ADDR_INPUT_PATH_ENABLES, 16'h0000);
			chk("idle clock", 16'h0000, 16'(s_clk));
		end
		frac = 1'b0;
		msel = 1'b1;
		repeat (3) step;
		wr(ADDR_PATH2_CONTROL, 16'h2400);
		wr(ADDR_INPUT_PATH_ENABLES, 16'h0008);
		meas;
		chk("mono half", 16'(HALF_3072K), 16'(n));
		chk("stereo idle", 16'h0000, 16'(s_clk));
		sys_en = 1'b0;
		repeat (3) step;
		wr(ADDR_INPUT_PATH_ENABLES, 16'h000B);
		chk("underclock", 16'h0001, 16'(last_err));
		rdc("status", ADDR_INPUT_PATH_ENABLE_STATUS, 16'h0008);
		sys_en = 1'b1;
		repeat (3) step;
		wr(ADDR_PATH1_CONTROL, 16'h4400);
		wr(ADDR_INPUT_PATH_ENABLES, 16'h000B);
		chk("reserved osr", 16'h0001, 16'(last_err));
		wr(ADDR_PATH1_CONTROL, 16'hFFFF);
		rdc("control", ADDR_PATH1_CONTROL, 16'h6400);
		wr(ADDR_PATH1_CONTROL, 16'h0000);
		wr(ADDR_INPUT_PATH_ENABLES, 16'h000B);
		chk("analogue enable", 16'h0000, 16'(last_err));
		repeat (40) step;
		chk("analogue clock", 16'h0000, 16'(s_clk));
		// No mute at these ports, so no unmute ordering to
		i_reset = 1'b1;
		repeat (2) step;
		i_reset = 1'b0;
		repeat (3) step;
		rdc("enables", ADDR_INPUT_PATH_ENABLES, ENABLES_RESET);
		rdc("status", ADDR_INPUT_PATH_ENABLE_STATUS, 16'h0000);
		rdc("control1", ADDR_PATH1_CONTROL, CONTROL_RESET);
		rdc("control2", ADDR_PATH2_CONTROL, CONTROL_RESET);
		rdc("unmapped", 16'h0302, 16'h0000);
		complete_run;
	end
endmodule // tb_pdmx_input_path
